// File: rtl/psso_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module psso_top #(
    parameter int NIN = psso_pkg::NUM_INPUTS
) (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [NIN-1:0]  inputValid,
    input  wire logic [4*NIN-1:0] inputPrio,
    input  wire logic            phaseLocked,
    input  wire logic            phaseLost,
    output logic      [5:0]      loopState,
    output logic      [2:0]      selectedInput,
    output logic                 forcedLoop,
    output logic                 forcedInput
);
    psso_pkg::psso_state_s stateFf;
    psso_pkg::psso_state_s nxtState;
    logic [NIN-1:0] validS1Ff;
    logic [NIN-1:0] validS2Ff;
    logic [1:0] lockS1Ff;
    logic [1:0] lockS2Ff;
    logic [2:0] forceIdx;
    logic [4*NIN-1:0] effPrio;
    logic [NIN-1:0] effValid;
    logic [2:0] bestIdx;
    logic [3:0] bestPrio;
    logic anyValid;
    logic wrEn;
    logic rdEn;
    logic addrOk;

    // ************************************************************
    // monitor input synchronisers
    // ************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            validS1Ff <= '0;
            validS2Ff <= '0;
            lockS1Ff  <= 2'h0;
            lockS2Ff  <= 2'h0;
        end else begin
            validS1Ff <= inputValid;
            validS2Ff <= validS1Ff;
            lockS1Ff  <= {phaseLost, phaseLocked};
            lockS2Ff  <= lockS1Ff;
        end
    end

    // ************************************************************
    // forced input decode and priority selection
    // ************************************************************
    always_comb begin
        case (stateFf.refOverride[3:0])
            psso_pkg::FI_SE1:     forceIdx = psso_pkg::IDX_SE1;
            psso_pkg::FI_SE2:     forceIdx = psso_pkg::IDX_SE2;
            psso_pkg::FI_DIFF1:   forceIdx = psso_pkg::IDX_DIFF1;
            psso_pkg::FI_DIFF2:   forceIdx = psso_pkg::IDX_DIFF2;
            psso_pkg::FI_STANDBY: forceIdx = psso_pkg::IDX_STANDBY;
            default:              forceIdx = psso_pkg::IDX_NONE;
        endcase
    end

    always_comb begin
        effPrio  = inputPrio;
        effValid = validS2Ff;
        for (int i = 0; i < NIN; i++) begin
            if (forceIdx == 3'(i)) begin
                effPrio[4*i +: 4] = psso_pkg::PRIO_HIGHEST;
                effValid[i] = 1'b1;
            end
        end
    end

    always_comb begin
        bestIdx  = psso_pkg::IDX_NONE;
        bestPrio = psso_pkg::PRIO_LOWEST;
        anyValid = 1'b0;
        for (int i = 0; i < NIN; i++) begin
            // lowest nonzero number wins; ties go to lower index
            if (effValid[i] && effPrio[4*i +: 4] != 4'h0 &&
                (!anyValid || effPrio[4*i +: 4] < bestPrio)) begin
                bestIdx  = 3'(i);
                bestPrio = effPrio[4*i +: 4];
                anyValid = 1'b1;
            end
        end
    end

    assign addrOk = (paddr == psso_pkg::LOOP_STATE_OVERRIDE_ADDR) ||
                    (paddr == psso_pkg::REF_INPUT_OVERRIDE_ADDR) ||
                    (paddr == psso_pkg::LOOP_STATUS_ADDR);
    assign wrEn = psel && penable && pwrite && addrOk;
    assign rdEn = psel && !penable && !pwrite;

    // ************************************************************
    // next state: registers, loop machine, read data
    // ************************************************************
    always_comb begin
        nxtState        = stateFf;
        nxtState.selIdx = bestIdx;
        if (wrEn && paddr == psso_pkg::LOOP_STATE_OVERRIDE_ADDR) begin
            nxtState.loopOverride = {5'h00, pwdata[2:0]};
        end
        if (wrEn && paddr == psso_pkg::REF_INPUT_OVERRIDE_ADDR) begin
            nxtState.refOverride = {4'h0, pwdata[3:0]};
        end
        if (stateFf.loopOverride[2:0] == psso_pkg::LS_AUTO) begin
            case (stateFf.loopState)
                psso_pkg::PSSO_FREERUN: begin
                    if (anyValid) nxtState.loopState = psso_pkg::PSSO_PRELOCK;
                end
                psso_pkg::PSSO_PRELOCK, psso_pkg::PSSO_PRELOCK2: begin
                    if (lockS2Ff[0]) nxtState.loopState = psso_pkg::PSSO_LOCKED;
                    else if (!anyValid) nxtState.loopState = psso_pkg::PSSO_HOLDOVER;
                end
                psso_pkg::PSSO_LOCKED: begin
                    // forced input keeps anyValid high, no holdover
                    if (!anyValid) nxtState.loopState = psso_pkg::PSSO_HOLDOVER;
                    else if (lockS2Ff[1]) nxtState.loopState = psso_pkg::PSSO_PHLOST;
                end
                psso_pkg::PSSO_PHLOST: begin
                    if (!anyValid) nxtState.loopState = psso_pkg::PSSO_HOLDOVER;
                    else if (!lockS2Ff[1]) nxtState.loopState = psso_pkg::PSSO_PRELOCK2;
                end
                psso_pkg::PSSO_HOLDOVER: begin
                    if (anyValid) nxtState.loopState = psso_pkg::PSSO_PRELOCK;
                end
                default: nxtState.loopState = psso_pkg::PSSO_FREERUN;
            endcase
        end else begin
            case (stateFf.loopOverride[2:0])
                psso_pkg::LS_FREERUN:  nxtState.loopState = psso_pkg::PSSO_FREERUN;
                psso_pkg::LS_HOLDOVER: nxtState.loopState = psso_pkg::PSSO_HOLDOVER;
                psso_pkg::LS_LOCKED:   nxtState.loopState = psso_pkg::PSSO_LOCKED;
                psso_pkg::LS_PRELOCK2: nxtState.loopState = psso_pkg::PSSO_PRELOCK2;
                psso_pkg::LS_PRELOCK:  nxtState.loopState = psso_pkg::PSSO_PRELOCK;
                psso_pkg::LS_PHLOST:   nxtState.loopState = psso_pkg::PSSO_PHLOST;
                default:               nxtState.loopState = stateFf.loopState;
            endcase
        end
        nxtState.prdata = 32'h0000_0000;
        if (rdEn) begin
            case (paddr)
                psso_pkg::LOOP_STATE_OVERRIDE_ADDR:
                    nxtState.prdata = {24'h00_0000, stateFf.loopOverride};
                psso_pkg::REF_INPUT_OVERRIDE_ADDR:
                    nxtState.prdata = {24'h00_0000, stateFf.refOverride};
                psso_pkg::LOOP_STATUS_ADDR:
                    nxtState.prdata = {23'h00_0000, stateFf.selIdx,
                                       stateFf.loopState};
                default: nxtState.prdata = 32'h0000_0000;
            endcase
        end else if (psel && penable) begin
            nxtState.prdata = stateFf.prdata;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stateFf.loopOverride <= psso_pkg::LOOP_STATE_RST;
            stateFf.refOverride  <= psso_pkg::REF_INPUT_RST;
            stateFf.loopState    <= psso_pkg::PSSO_FREERUN;
            stateFf.selIdx       <= psso_pkg::IDX_NONE;
            stateFf.prdata       <= 32'h0000_0000;
        end else begin
            stateFf <= nxtState;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata        = stateFf.prdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !addrOk;
    assign loopState     = stateFf.loopState;
    assign selectedInput = stateFf.selIdx;
    assign forcedLoop    = (stateFf.loopOverride[2:0] != psso_pkg::LS_AUTO);
    assign forcedInput   = (forceIdx != psso_pkg::IDX_NONE);
endmodule // psso_top
`default_nettype wire

// File: rtl/psso_pkg.sv
// Functional notes
// - override code zero lets the internal state machine choose the loop state.
// - nonzero code jumps loop into coded state; code 011 unused.
// - while forced, monitoring results never move the loop state.
// - forced input code zero leaves selection to automatic mechanism.
// - codes 0010..0101 pick first/second single-ended, first/second differential input.
// - a forced input counts as valid regardless of monitor results.
// - when forced input and not locked, advance through normal acquisition.
// - a failing forced input never sends the loop into holdover.
// - forcing raises that input's priority to 1, the highest, and marks it valid.
package psso_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] LOOP_STATE_OVERRIDE_ADDR = 8'h32;
    localparam logic [7:0] REF_INPUT_OVERRIDE_ADDR  = 8'h33;
    localparam logic [7:0] LOOP_STATUS_ADDR         = 8'h38;
    localparam logic [7:0] LOOP_STATE_RST           = 8'h00;
    localparam logic [7:0] REF_INPUT_RST            = 8'h0F;
    localparam int         NUM_INPUTS               = 5;
    localparam logic [3:0] PRIO_HIGHEST             = 4'h1;
    localparam logic [3:0] PRIO_LOWEST              = 4'hF;

    // ************************************************************
    // codes
    // ************************************************************
    localparam logic [2:0] LS_AUTO     = 3'h0;
    localparam logic [2:0] LS_FREERUN  = 3'h1;
    localparam logic [2:0] LS_HOLDOVER = 3'h2;
    localparam logic [2:0] LS_UNUSED   = 3'h3;
    localparam logic [2:0] LS_LOCKED   = 3'h4;
    localparam logic [2:0] LS_PRELOCK2 = 3'h5;
    localparam logic [2:0] LS_PRELOCK  = 3'h6;
    localparam logic [2:0] LS_PHLOST   = 3'h7;
    localparam logic [3:0] FI_AUTO     = 4'h0;
    localparam logic [3:0] FI_SE1      = 4'h2;
    localparam logic [3:0] FI_SE2      = 4'h3;
    localparam logic [3:0] FI_DIFF1    = 4'h4;
    localparam logic [3:0] FI_DIFF2    = 4'h5;
    localparam logic [3:0] FI_STANDBY  = 4'h8;
    localparam logic [2:0] IDX_SE1     = 3'h0;
    localparam logic [2:0] IDX_SE2     = 3'h1;
    localparam logic [2:0] IDX_DIFF1   = 3'h2;
    localparam logic [2:0] IDX_DIFF2   = 3'h3;
    localparam logic [2:0] IDX_STANDBY = 3'h4;
    localparam logic [2:0] IDX_NONE    = 3'h7;

    typedef enum logic [5:0] {
        PSSO_FREERUN  = 6'h01,
        PSSO_HOLDOVER = 6'h02,
        PSSO_LOCKED   = 6'h04,
        PSSO_PRELOCK2 = 6'h08,
        PSSO_PRELOCK  = 6'h10,
        PSSO_PHLOST   = 6'h20
    } psso_loop_e;

    typedef struct packed {
        logic [7:0] loopOverride;
        logic [7:0] refOverride;
        psso_loop_e loopState;
        logic [2:0] selIdx;
        logic [31:0] prdata;
    } psso_state_s;
endpackage : psso_pkg

// File: bench/psso_chk.sv
`timescale 1ns/1ns
`default_nettype none
module psso_chk (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  loopState,
    input wire logic [2:0]  selectedInput,
    input wire logic        forcedLoop,
    input wire logic        forcedInput
);
    // ****************
    // port checks
    // ****************
    wire logic wrEn = psel && penable && pwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // bus answers
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_map: assert property (psel && penable |->
        pslverr == !(paddr inside {8'h32, 8'h33, 8'h38})) else $error("pslverr wrong");
    chk_idle_zero: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    // override flags follow the written code
    chk_loop_flag: assert property (wrEn && paddr == 8'h32 |=>
        forcedLoop == ($past(pwdata[2:0]) != 3'h0)) else $error("loop force flag wrong");
    chk_input_flag: assert property (wrEn && paddr == 8'h33 |=>
        forcedInput == ($past(pwdata[3:0]) inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8}))
        else $error("input force flag wrong");
    // forced loop state holds once forced for four cycles without a write
    chk_forced_hold: assert property ((forcedLoop && !wrEn)[*4] |-> $stable(loopState))
        else $error("forced loop state moved");
    // with a forced input some input is always selected, and with the loop state not forced holdover is never entered
    chk_sel_valid: assert property ((forcedInput && !forcedLoop && !wrEn)[*5]
        |-> selectedInput != 3'h7) else $error("forced input not selected");
    chk_no_holdover: assert property ((forcedInput && !forcedLoop)[*3]
        ##0 $past(loopState) != 6'h02 |-> loopState != 6'h02) else $error("holdover entered");
    // main scenarios
    cover property (forcedLoop ##4 forcedLoop);
    cover property (forcedInput && loopState == 6'h04);
    cover property (psel && penable && pslverr);
endmodule // psso_chk

bind psso_top psso_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loopState(loopState), .selectedInput(selectedInput),
    .forcedLoop(forcedLoop), .forcedInput(forcedInput));
`default_nettype wire

// File: bench/psso_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        ref_clk = 1'h0;
    logic        nrst = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [4:0]  inputValid = 5'h1F;
    logic [19:0] inputPrio = 20'h54321;
    logic        phaseLocked = 1'h1;
    logic        phaseLost = 1'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, forcedLoop, forcedInput, er;
    logic [5:0]  loopState;
    logic [2:0]  selectedInput;
    logic [27:0] r;
    int          errTotal = 0;
    int          nTests = 0;
    // rows: expected view (FF unchecked), force flag, address, write data
    logic [27:0] rows [19] = '{28'h01_1_32_F9, 28'h02_1_32_02, 28'h04_1_32_04, 28'h08_1_32_05,
        28'h10_1_32_06, 28'h20_1_32_07, 28'h20_1_32_03, 28'hFF_0_32_00, 28'h00_1_33_02,
        28'h01_1_33_03, 28'h02_1_33_F4, 28'h03_1_33_05, 28'h04_1_33_08, 28'hFF_0_33_01,
        28'hFF_0_33_06, 28'hFF_0_33_07, 28'hFF_0_33_09, 28'hFF_0_33_0F, 28'hFF_0_33_00};

    // clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    psso_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inputValid(inputValid), .inputPrio(inputPrio),
        .phaseLocked(phaseLocked), .phaseLost(phaseLost), .loopState(loopState),
        .selectedInput(selectedInput), .forcedLoop(forcedLoop), .forcedInput(forcedInput));

    // ****************
    // bus and check tasks
    // ****************
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            errTotal++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic do_reset;
        nrst <= 1'h0;
        repeat (6) @(posedge ref_clk);
        chk("loop rst", 32'h1, {26'h0, loopState});
        chk("sel rst", 32'h7, {29'h0, selectedInput});
        nrst <= 1'h1;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        do_reset();
        apb(1'h0, 8'h33, 32'h0);
        chk("ref rst", 32'hF, rd);
        for (int i = 0; i < 19; i++) begin
            r = rows[i];
            inputValid <= (r[15:8] == 8'h33) ? 5'h00 : 5'h1F;
            apb(1'h1, r[15:8], {24'h0, r[7:0]});
            apb(1'h0, r[15:8], 32'h0);
            chk("readback", {24'h0, r[7:0] & ((r[15:8] == 8'h32) ? 8'h07 : 8'h0F)}, rd);
            repeat (4) @(posedge ref_clk);
            chk("flag", {31'h0, r[16]}, {31'h0, (r[15:8] == 8'h32) ? forcedLoop : forcedInput});
            if (r[27:20] != 8'hFF) chk("view", {24'h0, r[27:20]},
                (r[15:8] == 8'h32) ? {26'h0, loopState} : {29'h0, selectedInput});
        end
        apb(1'h1, 8'h40, 32'hFF);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped rd", 32'h0, rd);
        apb(1'h1, 8'h32, 32'h4);
        phaseLost <= 1'h1;
        inputValid <= 5'h00;
        repeat (8) @(posedge ref_clk);
        chk("forced hold", 32'h4, {26'h0, loopState});
        apb(1'h0, 8'h38, 32'h0);
        chk("status", 32'h1C4, rd);
        apb(1'h1, 8'h32, 32'h0);
        repeat (4) @(posedge ref_clk);
        chk("auto holdover", 32'h2, {26'h0, loopState});
        inputValid <= 5'h01;
        phaseLost <= 1'h0;
        repeat (6) @(posedge ref_clk);
        chk("relock", 32'h4, {26'h0, loopState});
        phaseLost <= 1'h1;
        repeat (4) @(posedge ref_clk);
        chk("phase lost", 32'h20, {26'h0, loopState});
        phaseLost <= 1'h0;
        repeat (6) @(posedge ref_clk);
        chk("recovered", 32'h4, {26'h0, loopState});
        do_reset();
        inputValid <= 5'h00;
        apb(1'h1, 8'h33, 32'h4);
        repeat (12) @(posedge ref_clk);
        chk("lock", 32'h4, {26'h0, loopState});
        chk("forced sel", 32'h2, {29'h0, selectedInput});
        apb(1'h1, 8'h33, 32'h0);
        inputValid <= 5'h02;
        repeat (8) @(posedge ref_clk);
        chk("auto sel", 32'h1, {29'h0, selectedInput});
        close_out();
    end
endmodule // testbench
`default_nettype wire
